// file: rtl/mdma_top.sv
// ten-channel dma engine with byte-wide rom boot run by its own sequencer, apart from channel 0
// assumes descriptors come from an outside loader and an outside datapath moves each word
//
// Contract
// RL1: ten independent channels move data with no core instruction involvement.
// RL2: channels run alongside core execution, invisible except for moved data.
// RL3: serve external master to internal/link, and external memory to peripherals/link.
// RL4: four external channels, each in master or handshake mode.
// RL5: two transmit, two receive link channels move quad-words under handshake only.
// RL6: the two link receive channels take turns when both request.
// RL7: two slave channels accept data only when an external master starts.
// RL8: flyby runs only on channel 0, from an io device into sdram; the code also runs it from sdram to the io device when to_ext is set.
// RL9: flyby releases data bus, drives address, selects, io strobes, waits acknowledge.
// RL10: io device drives data while read strobe active, acknowledges when valid.
// RL11: a finished sequence may start another channel with other attributes.
// RL12: transmit and receive channels step x and y with own count and modify.
// RL13: with boot strap set, load rom program into internal memory after reset.
// RL14: each boot rom read waits 16 cycles before sampling the byte.
// RL15: during boot the boot rom select acts as rom chip select.
// RL16: boot uses channel 0, packing four rom bytes per 32-bit word; the code boots through its own sequencer, not channel 0.
// RL17: rom space is byte addressed, 24 address bits, outside memory map.
// RL18: after boot the rom is reached only through a dma channel.
// RL19: link buffers are filled or drained by core or by link channels.
// RL20: transmit end pulses block done out; block done in ends receive; the code acts on block done in only while in ST_IDLE.
// RL21: pending external channels are served lowest number first.
`timescale 1ns/1ps
`include "mdma_params.svh"
module mdma_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // boot strap and byte-wide rom
  input wire logic boot_rom_en_i,
  input wire logic [`MDMA_CW-1:0] boot_words_i,
  input wire logic [`MDMA_BYTE_W-1:0] rom_data_i,
  output logic [`MDMA_ROM_AW-1:0] rom_addr_o,
  output logic boot_rom_select_n_o,
  output logic boot_done_o,
  // internal memory write port for boot words
  output logic imem_we_o,
  output logic [`MDMA_AW-1:0] imem_waddr_o,
  output logic [`MDMA_AW-1:0] imem_wdata_o,
  input wire logic imem_ready_i,
  // descriptor load
  input wire logic tcb_we_i,
  input wire logic [`MDMA_CHW-1:0] tcb_chan_i,
  input wire mdma_pkg::mdma_desc_t tcb_i,
  // channel requests
  input wire logic [`MDMA_N_EXT-1:0] ext_dmar_i,
  input wire logic [`MDMA_NLINK-1:0] link_tx_room_i,
  input wire logic [`MDMA_NLINK-1:0] link_rx_avail_i,
  input wire logic [`MDMA_NLINK-1:0] slave_req_i,
  // word transfer request to the datapath
  output logic xfer_valid_o,
  output logic [`MDMA_CHW-1:0] xfer_chan_o,
  output logic [`MDMA_AW-1:0] xfer_addr_o,
  output logic xfer_to_ext_o,
  output logic xfer_quad_o,
  input wire logic xfer_ready_i,
  // external bus strobes for flyby
  input wire logic ext_ack_i,
  output logic [`MDMA_NBANK-1:0] sdram_bank_selects_n_o,
  output logic io_read_strobe_n_o,
  output logic io_write_strobe_n_o,
  output logic io_enable_strobe_n_o,
  output logic rd_wr_o,
  output logic ext_data_oe_o,
  // link block completion
  output logic [`MDMA_NLINK-1:0] link_tx_block_done_n_o,
  input wire logic [`MDMA_NLINK-1:0] link_rx_block_done_n_i,
  // status
  output logic [`MDMA_NCH-1:0] ch_active_o,
  output logic [`MDMA_NCH-1:0] ch_done_o
);
  import mdma_pkg::*;

  localparam logic [`MDMA_WAITW-1:0] BOOT_WAIT_C = `MDMA_WAITW'(`MDMA_BOOT_WAIT);
  localparam int BANKW = $clog2(`MDMA_NBANK);

  mdma_state_t q, d;
  mdma_desc_t cd;
  logic [`MDMA_NCH-1:0] req;
  logic [`MDMA_NCH-1:0] pend;
  logic [`MDMA_CHW:0] gnt;
  logic take;
  logic beat;
  logic last;
  logic fly;

  mdma_stream_if #(.W(`MDMA_AW)) boot_in ();
  mdma_stream_if #(.W(`MDMA_AW)) boot_out ();

  // four words of slack let rom reads continue while memory stalls
  mdma_fifo #(
    .WIDTH(`MDMA_AW),
    .DEPTH(`MDMA_FIFO_DEPTH)
  ) u_boot_fifo (
    .clk_i(ref_clk_i),
    .rst_i(reset_i),
    .in_s(boot_in),
    .out_s(boot_out)
  );

  function automatic logic is_last(input mdma_desc_t c);
    return c.x_left <= `MDMA_CW'(1) && c.y_left <= `MDMA_CW'(1);
  endfunction

  // x runs to its count, then y adds its modify and reloads x
  function automatic mdma_desc_t step(input mdma_desc_t c);
    mdma_desc_t n;
    n = c;
    if (c.x_left > `MDMA_CW'(1)) begin
      n.addr = c.addr + `MDMA_AW'(signed'(c.x_mod));
      n.x_left = c.x_left - 1'b1;
    end else if (c.y_left > `MDMA_CW'(1)) begin
      n.addr = c.addr + `MDMA_AW'(signed'(c.y_mod));
      n.x_left = c.x_cnt;
      n.y_left = c.y_left - 1'b1;
    end else begin
      n.active = 1'b0;
    end
    return n;
  endfunction

  // lowest channel wins, except the receive pair alternates
  function automatic logic [`MDMA_CHW:0] pick(input logic [`MDMA_NCH-1:0] p,
                                               input logic rx_last);
    logic [`MDMA_CHW:0] g;
    g = '0;
    for (int i = `MDMA_NCH - 1; i >= 0; i--) begin
      if (p[i]) begin
        g = {1'b1, `MDMA_CHW'(i)}; // RL21
      end
    end
    if (g[`MDMA_CHW-1:0] == `MDMA_CHW'(`MDMA_CH_RX0) && p[`MDMA_CH_RX0 + 1] && !rx_last) begin
      g = {1'b1, `MDMA_CHW'(`MDMA_CH_RX0 + 1)}; // RL6
    end
    return g;
  endfunction

  always_comb begin
    for (int i = 0; i < `MDMA_N_EXT; i++) begin
      req[i] = q.ch[i].hs ? ext_dmar_i[i] : 1'b1; // RL4
    end
    for (int i = 0; i < `MDMA_NLINK; i++) begin
      req[`MDMA_CH_TX0 + i] = link_tx_room_i[i]; // RL19
      req[`MDMA_CH_RX0 + i] = link_rx_avail_i[i]; // RL19
      req[`MDMA_CH_SLV0 + i] = slave_req_i[i]; // RL7
    end
    for (int i = 0; i < `MDMA_NCH; i++) begin
      pend[i] = q.ch[i].active && req[i];
    end
    gnt = pick(pend, q.rx_last);
  end

  assign cd = q.ch[q.cur];
  assign take = q.st == ST_BOOT_RD && q.wait_cnt == BOOT_WAIT_C; // RL14
  assign fly = q.st == ST_FLYBY;
  assign beat = (q.st == ST_XFER && xfer_ready_i) || (fly && ext_ack_i); // RL10
  assign last = is_last(cd);

  assign boot_in.valid = q.st == ST_BOOT_PUSH;
  assign boot_in.data = q.pack;
  assign boot_out.ready = imem_ready_i;

  // engine state moves on its own; the core only sees memory change
  always_comb begin
    d = q; // RL2
    d.done = '0;
    d.tx_done = '0;
    if (boot_out.valid && imem_ready_i) begin
      d.boot_waddr = q.boot_waddr + `MDMA_AW'(`MDMA_WORD_BYTES);
    end
    unique case (q.st)
      ST_RESET: begin
        d.boot_left = boot_words_i;
        if (boot_rom_en_i && boot_words_i != '0) begin
          d.st = ST_BOOT_RD; // RL13
        end else begin
          d.st = ST_IDLE;
          d.boot_done = 1'b1;
        end
      end
      ST_BOOT_RD: begin
        if (take) begin
          d.pack = {rom_data_i, q.pack[`MDMA_AW-1:`MDMA_BYTE_W]}; // RL16
          d.rom_addr = q.rom_addr + 1'b1; // RL17
          d.wait_cnt = '0;
          d.byte_idx = q.byte_idx + 1'b1;
          if (&q.byte_idx) begin
            d.st = ST_BOOT_PUSH;
          end
        end else begin
          d.wait_cnt = q.wait_cnt + 1'b1;
        end
      end
      ST_BOOT_PUSH: begin
        if (boot_in.ready) begin
          d.boot_left = q.boot_left - 1'b1;
          if (q.boot_left == `MDMA_CW'(1)) begin
            d.st = ST_IDLE;
            d.boot_done = 1'b1;
          end else begin
            d.st = ST_BOOT_RD;
          end
        end
      end
      ST_IDLE: begin
        for (int i = 0; i < `MDMA_NLINK; i++) begin
          if (!link_rx_block_done_n_i[i] && q.ch[`MDMA_CH_RX0 + i].active) begin
            d.ch[`MDMA_CH_RX0 + i].active = 1'b0; // RL20
            d.done[`MDMA_CH_RX0 + i] = 1'b1;
          end
        end
        if (gnt[`MDMA_CHW]) begin
          d.cur = gnt[`MDMA_CHW-1:0]; // RL1
          if (gnt[`MDMA_CHW-1:0] == `MDMA_CHW'(`MDMA_FLYBY_CH)
              && q.ch[`MDMA_FLYBY_CH].flyby) begin
            d.st = ST_FLYBY; // RL8
          end else begin
            d.st = ST_XFER; // RL3
          end
          if (gnt[`MDMA_CHW-1:1] == `MDMA_CH_RX0 >> 1) begin
            d.rx_last = gnt[0]; // RL6
          end
        end
      end
      ST_XFER, ST_FLYBY: begin
        if (beat) begin
          d.ch[q.cur] = step(cd); // RL12
          d.st = ST_IDLE;
          if (last) begin
            d.done[q.cur] = 1'b1;
            if (q.cur[`MDMA_CHW-1:1] == `MDMA_CH_TX0 >> 1) begin
              d.tx_done[q.cur[0]] = 1'b1; // RL20
            end
            if (cd.chain && cd.chain_ch < `MDMA_CHW'(`MDMA_NCH)) begin
              d.ch[cd.chain_ch].active = 1'b1; // RL11
            end
          end
        end
      end
    endcase
    // a fresh descriptor overrides whatever the channel held
    if (tcb_we_i && tcb_chan_i < `MDMA_CHW'(`MDMA_NCH)) begin
      d.ch[tcb_chan_i] = tcb_i; // RL1
      d.ch[tcb_chan_i].active = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // rom is reached by boot or by a channel flagged for it, never by plain addressing
  assign boot_rom_select_n_o = !(q.st == ST_BOOT_RD
                                || (q.st == ST_XFER && cd.rom)); // RL15 RL18
  assign rom_addr_o = (q.st == ST_BOOT_RD) ? q.rom_addr : cd.addr[`MDMA_ROM_AW-1:0]; // RL17
  assign boot_done_o = q.boot_done && !boot_out.valid;
  assign imem_we_o = boot_out.valid;
  assign imem_waddr_o = q.boot_waddr;
  assign imem_wdata_o = boot_out.data;

  assign xfer_valid_o = q.st == ST_XFER;
  assign xfer_chan_o = q.cur;
  assign xfer_addr_o = cd.addr;
  assign xfer_to_ext_o = cd.to_ext;
  assign xfer_quad_o = q.cur >= `MDMA_CHW'(`MDMA_CH_TX0)
                       && q.cur < `MDMA_CHW'(`MDMA_CH_SLV0); // RL5

  // flyby: data bus released, io strobes steer the peripheral
  always_comb begin
    for (int b = 0; b < `MDMA_NBANK; b++) begin
      sdram_bank_selects_n_o[b] = !(fly && cd.addr[`MDMA_BANK_LSB +: BANKW] == BANKW'(b)); // RL9
    end
  end
  assign io_read_strobe_n_o = !(fly && !cd.to_ext); // RL9
  assign io_write_strobe_n_o = !(fly && cd.to_ext);
  assign io_enable_strobe_n_o = !fly;
  assign rd_wr_o = fly ? cd.to_ext : !cd.to_ext;
  assign ext_data_oe_o = q.st == ST_XFER && cd.to_ext;

  assign link_tx_block_done_n_o = ~q.tx_done;
  always_comb begin
    for (int i = 0; i < `MDMA_NCH; i++) begin
      ch_active_o[i] = q.ch[i].active;
    end
  end
  assign ch_done_o = q.done;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_byte_start;
    q.st == ST_BOOT_RD && q.wait_cnt == '0;
  endsequence
  sequence s_byte_take;
    take && !boot_rom_select_n_o;
  endsequence
  sequence s_last_byte;
    take && &q.byte_idx;
  endsequence
  sequence s_tx0_end;
    beat && last && q.cur == `MDMA_CHW'(`MDMA_CH_TX0);
  endsequence

  AST_BOOT_WAIT: assert property (s_byte_start |-> ##16 s_byte_take) // RL14
    else $error("boot byte not sampled after sixteen waits");
  AST_BOOT_SEL: assert property (q.st == ST_BOOT_RD |-> !boot_rom_select_n_o) // RL15
    else $error("rom select idle during boot read");
  AST_BOOT_PACK: assert property (s_last_byte |=> boot_in.valid // RL16
      && boot_in.data[`MDMA_AW-1 -: `MDMA_BYTE_W] == $past(rom_data_i))
    else $error("fourth byte not in top of packed word");
  AST_TCB_LOAD: assert property (tcb_we_i && tcb_chan_i < `MDMA_CHW'(`MDMA_NCH) // RL1
      |=> q.ch[$past(tcb_chan_i)].active)
    else $error("loaded channel not active");
  AST_EXT_PRI: assert property (q.st == ST_IDLE && gnt[`MDMA_CHW] // RL21
      && gnt[`MDMA_CHW-1:0] < `MDMA_CHW'(`MDMA_N_EXT)
      |-> (pend & ~({`MDMA_NCH{1'b1}} << gnt[`MDMA_CHW-1:0])) == '0)
    else $error("lower external channel skipped");
  AST_RX_ROT: assert property (q.st == ST_IDLE && pend[`MDMA_CH_RX0] // RL6
      && pend[`MDMA_CH_RX0 + 1] && gnt[`MDMA_CHW-1:1] == `MDMA_CH_RX0 >> 1
      |-> gnt[0] != q.rx_last)
    else $error("receive channel served twice in a row");
  AST_SLAVE: assert property (q.st == ST_IDLE && gnt[`MDMA_CHW] // RL7
      && gnt[`MDMA_CHW-1:0] >= `MDMA_CHW'(`MDMA_CH_SLV0) |-> slave_req_i[gnt[0]])
    else $error("slave channel ran without master");
  AST_FLYBY_CH0: assert property (fly |-> q.cur == `MDMA_CHW'(`MDMA_FLYBY_CH)) // RL8
    else $error("flyby on other channel");
  AST_FLYBY_BUS: assert property (fly && !ext_ack_i // RL9
      |-> !ext_data_oe_o && !io_enable_strobe_n_o ##1 fly)
    else $error("flyby left before acknowledge or bus driven");
  AST_CHAIN: assert property (beat && last && cd.chain // RL11
      && cd.chain_ch < `MDMA_CHW'(`MDMA_NCH) |=> q.ch[$past(cd.chain_ch)].active)
    else $error("chained channel not started");
  AST_TWO_D: assert property (beat && !last && cd.x_left <= `MDMA_CW'(1) // RL12
      |=> q.ch[$past(q.cur)].x_left == $past(cd.x_cnt))
    else $error("x count not reloaded on y step");
  AST_TX_DONE: assert property (s_tx0_end |=> !link_tx_block_done_n_o[0] // RL20
      ##1 link_tx_block_done_n_o[0])
    else $error("transmit block done not pulsed");
endmodule

// file: shared/mdma_params.svh
// constants of the multichannel dma engine: channel map, widths, boot timing
// assumes it is included by the package and by every design file that needs it
`ifndef MDMA_PARAMS_SVH
`define MDMA_PARAMS_SVH
`define MDMA_NCH 10
`define MDMA_CHW 4
`define MDMA_AW 32
`define MDMA_CW 16
`define MDMA_N_EXT 4
`define MDMA_NLINK 2
`define MDMA_CH_TX0 4
`define MDMA_CH_RX0 6
`define MDMA_CH_SLV0 8
`define MDMA_FLYBY_CH 0
`define MDMA_BOOT_WAIT 16
`define MDMA_WAITW 5
`define MDMA_ROM_AW 24
`define MDMA_BYTE_W 8
`define MDMA_WORD_BYTES 4
`define MDMA_FIFO_DEPTH 4
`define MDMA_BANK_LSB 26
`define MDMA_NBANK 4
`endif

// file: shared/mdma_pkg.sv
// types of the multichannel dma engine
// assumes mdma_params.svh is on the include path
`include "mdma_params.svh"
package mdma_pkg;
  typedef struct packed {
    logic active;
    logic rom;
    logic flyby;
    logic hs;
    logic to_ext;
    logic chain;
    logic [`MDMA_CHW-1:0] chain_ch;
    logic [`MDMA_AW-1:0] addr;
    logic [`MDMA_CW-1:0] x_cnt;
    logic [`MDMA_CW-1:0] x_mod;
    logic [`MDMA_CW-1:0] x_left;
    logic [`MDMA_CW-1:0] y_left;
    logic [`MDMA_CW-1:0] y_mod;
  } mdma_desc_t;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_BOOT_RD,
    ST_BOOT_PUSH,
    ST_IDLE,
    ST_XFER,
    ST_FLYBY
  } mdma_st_t;

  typedef struct packed {
    mdma_st_t st;
    mdma_desc_t [`MDMA_NCH-1:0] ch;
    logic [`MDMA_CHW-1:0] cur;
    logic rx_last;
    logic [`MDMA_WAITW-1:0] wait_cnt;
    logic [1:0] byte_idx;
    logic [`MDMA_AW-1:0] pack;
    logic [`MDMA_ROM_AW-1:0] rom_addr;
    logic [`MDMA_CW-1:0] boot_left;
    logic [`MDMA_AW-1:0] boot_waddr;
    logic boot_done;
    logic [`MDMA_NLINK-1:0] tx_done;
    logic [`MDMA_NCH-1:0] done;
  } mdma_state_t;
endpackage

// file: shared/mdma_stream_if.sv
// valid/ready word stream between the engine and its buffer
// assumes both ends share one clock
`timescale 1ns/1ps
interface mdma_stream_if #(parameter int W = 32) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: rtl/mdma_fifo.sv
// small word fifo with valid/ready on both sides
// assumes DEPTH is a power of two and WIDTH matches the interfaces
`timescale 1ns/1ps
module mdma_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill and drain sides
  mdma_stream_if.snk in_s,
  mdma_stream_if.src out_s
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] cnt;
  } mdma_fifo_st_t;
  mdma_fifo_st_t q, d;
  logic push;
  logic pop;

  assign in_s.ready = q.cnt != (PW + 1)'(DEPTH);
  assign out_s.valid = q.cnt != '0;
  assign out_s.data = q.mem[q.rd];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_s.data;
      d.wr = q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
    d.cnt = q.cnt + (PW + 1)'(push) - (PW + 1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// file: test/mdma_far_model.sv
// far side of the dma engine: byte rom, internal memory port, word datapath, flyby io device
// assumes one shared clock; dly_i paces every answer so the bench can stall the engine
`timescale 1ns/1ps
module mdma_far_model (
  // clock and pacing
  input wire logic ref_clk_i,
  input wire logic [1:0] dly_i,
  // byte rom
  input wire logic [23:0] rom_addr_i,
  input wire logic rom_sel_n_i,
  output logic [7:0] rom_data_o,
  // requests and answers
  input wire logic imem_we_i,
  output logic imem_ready_o,
  input wire logic xfer_valid_i,
  output logic xfer_ready_o,
  input wire logic io_en_n_i,
  output logic ext_ack_o
);
  logic [23:0] prev_q;
  logic [4:0] age_q;
  logic [7:0] last_q;
  logic [1:0] cnt_q;
  logic ok;
  logic req;
  // rom data settles late; an early sample or a deselected rom yields a toggling junk byte
  assign ok = !rom_sel_n_i && rom_addr_i == prev_q && age_q >= 5'h0E;
  assign rom_data_o = ok ? rom_addr_i[7:0] ^ 8'hA5 : ~last_q;
  assign req = imem_we_i | xfer_valid_i | !io_en_n_i;
  initial begin
    prev_q = 24'h000000;
    age_q = 5'h00;
    last_q = 8'h00;
    cnt_q = 2'h0;
    imem_ready_o = 1'b0;
    xfer_ready_o = 1'b0;
    ext_ack_o = 1'b0;
  end
  always @(posedge ref_clk_i) begin
    prev_q <= rom_addr_i;
    last_q <= rom_data_o;
    age_q <= (ok || (!rom_sel_n_i && rom_addr_i == prev_q)) ? age_q + {4'h0, age_q != 5'h1F} : 5'h00;
    imem_ready_o <= 1'b0;
    xfer_ready_o <= 1'b0;
    ext_ack_o <= 1'b0;
    if (req && !(imem_ready_o | xfer_ready_o | ext_ack_o)) begin
      if (cnt_q == dly_i) begin
        cnt_q <= 2'h0;
        imem_ready_o <= imem_we_i;
        xfer_ready_o <= xfer_valid_i;
        ext_ack_o <= !io_en_n_i;
      end else begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end
endmodule

// file: test/tb.sv
// self-checking bench of the dma engine: boot, priority, link, slave, chain and flyby
// assumes mdma_top and mdma_far_model are compiled first
`timescale 1ns/1ps
module tb;
  import mdma_pkg::*;
  logic ref_clk_i, reset_i, boot_en, rom_sel_n, boot_done, imem_we, imem_ready, tcb_we, xv, xr;
  logic to_ext, quad, ack, rd_n, wr_n, en_n, rd_wr, oe;
  logic [1:0] dly, tx_room, rx_avail, slave_req, tx_done_n, rx_done_n;
  logic [3:0] tcb_chan, dmar, bank_n, xch, c;
  logic [7:0] rom_data;
  logic [15:0] boot_words;
  logic [23:0] rom_addr;
  logic [31:0] iaddr, idata, xaddr, a;
  logic [9:0] act, done;
  logic q;
  mdma_desc_t tcb;
  int n_mismatch, total_checks;

  mdma_top uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .boot_rom_en_i(boot_en),
    .boot_words_i(boot_words), .rom_data_i(rom_data), .rom_addr_o(rom_addr),
    .boot_rom_select_n_o(rom_sel_n), .boot_done_o(boot_done), .imem_we_o(imem_we),
    .imem_waddr_o(iaddr), .imem_wdata_o(idata), .imem_ready_i(imem_ready), .tcb_we_i(tcb_we),
    .tcb_chan_i(tcb_chan), .tcb_i(tcb), .ext_dmar_i(dmar), .link_tx_room_i(tx_room),
    .link_rx_avail_i(rx_avail), .slave_req_i(slave_req), .xfer_valid_o(xv), .xfer_chan_o(xch),
    .xfer_addr_o(xaddr), .xfer_to_ext_o(to_ext), .xfer_quad_o(quad), .xfer_ready_i(xr),
    .ext_ack_i(ack), .sdram_bank_selects_n_o(bank_n), .io_read_strobe_n_o(rd_n),
    .io_write_strobe_n_o(wr_n), .io_enable_strobe_n_o(en_n), .rd_wr_o(rd_wr),
    .ext_data_oe_o(oe), .link_tx_block_done_n_o(tx_done_n), .link_rx_block_done_n_i(rx_done_n),
    .ch_active_o(act), .ch_done_o(done));
  mdma_far_model u_far (.ref_clk_i(ref_clk_i), .dly_i(dly), .rom_addr_i(rom_addr),
    .rom_sel_n_i(rom_sel_n), .rom_data_o(rom_data), .imem_we_i(imem_we),
    .imem_ready_o(imem_ready), .xfer_valid_i(xv), .xfer_ready_o(xr), .io_en_n_i(en_n),
    .ext_ack_o(ack));

  task automatic tally_and_finish();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic load(input logic [3:0] ch, input logic hs, input logic fly, input logic cn,
                      input logic [3:0] cc, input logic [31:0] ad, input logic [15:0] n);
    @(posedge ref_clk_i);
    tcb_we <= 1'b1;
    tcb_chan <= ch;
    tcb <= '{active:1'b1, rom:1'b0, flyby:fly, hs:hs, to_ext:!fly, chain:cn, chain_ch:cc,
             addr:ad, x_cnt:n, x_mod:16'h0004, x_left:n, y_left:16'h0000, y_mod:16'h0000};
    @(posedge ref_clk_i);
    tcb_we <= 1'b0;
  endtask
  // returns at the negedge before the edge that takes the beat
  task automatic beat();
    int i;
    for (i = 0; i < 300; i++) begin
      @(negedge ref_clk_i);
      if (xv && xr) break;
    end
    if (i == 300) begin
      n_mismatch++;
      tally_and_finish();
    end
    c = xch;
    a = xaddr;
    q = quad;
  endtask
  task automatic idle_for(input int n);
    repeat (n) begin
      @(negedge ref_clk_i);
      chk(xv, 1'b0);
    end
  endtask

  task automatic s_boot();
    int i, k;
    k = 0;
    for (i = 0; i < 800 && boot_done !== 1'b1; i++) begin
      @(negedge ref_clk_i);
      if (imem_we && imem_ready) begin
        chk(iaddr, 32'(k * 4));
        chk(idata, {8'(4*k+3), 8'(4*k+2), 8'(4*k+1), 8'(4*k)} ^ 32'hA5A5A5A5);
        k++;
      end
    end
    if (boot_done !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
    chk(k, 2);
  endtask
  task automatic s_prio();
    load(4'h2, 1'b1, 1'b0, 1'b0, 4'h0, 32'h200, 16'h0001);
    load(4'h1, 1'b1, 1'b0, 1'b0, 4'h0, 32'h100, 16'h0001);
    idle_for(6);
    @(posedge ref_clk_i);
    dmar <= 4'h6;
    beat();
    chk({c, a}, {4'h1, 32'h100});
    beat();
    chk(c, 4'h2);
    @(posedge ref_clk_i);
    dmar <= 4'h0;
  endtask
  task automatic s_link();
    logic [3:0] p;
    load(4'h6, 1'b0, 1'b0, 1'b0, 4'h0, 32'h300, 16'h0002);
    load(4'h7, 1'b0, 1'b0, 1'b0, 4'h0, 32'h400, 16'h0002);
    @(posedge ref_clk_i);
    rx_avail <= 2'h3;
    for (int i = 0; i < 4; i++) begin
      beat();
      chk(q, 1'b1);
      if (i > 0) chk(c, p ^ 4'h1);
      chk(a, (c == 4'h6 ? 32'h300 : 32'h400) + (i > 1 ? 32'h4 : 32'h0));
      p = c;
    end
    @(posedge ref_clk_i);
    rx_avail <= 2'h0;
    idle_for(3);
    chk(act[7:6], 2'h0);
    @(posedge ref_clk_i);
    tx_room <= 2'h1;
    load(4'h4, 1'b0, 1'b0, 1'b0, 4'h0, 32'h500, 16'h0001);
    beat();
    chk({c, q}, {4'h4, 1'b1});
    p = 4'h0;
    repeat (4) begin
      @(negedge ref_clk_i);
      if (tx_done_n[0] === 1'b0 && done[4] === 1'b1) p++;
    end
    chk(p, 4'h1);
  endtask
  task automatic s_rx_end_chain();
    load(4'h7, 1'b0, 1'b0, 1'b0, 4'h0, 32'h700, 16'h0004);
    idle_for(2);
    chk(act[7], 1'b1);
    @(posedge ref_clk_i);
    rx_done_n <= 2'h1;
    @(posedge ref_clk_i);
    rx_done_n <= 2'h3;
    idle_for(3);
    chk(act[7], 1'b0);
    // the stopped receive block still holds its own attributes for the chained start
    load(4'h3, 1'b0, 1'b0, 1'b1, 4'h7, 32'h600, 16'h0001);
    beat();
    chk({c, a, q}, {4'h3, 32'h600, 1'b0});
    @(posedge ref_clk_i);
    rx_avail <= 2'h2;
    beat();
    chk({c, a, q}, {4'h7, 32'h700, 1'b1});
    @(posedge ref_clk_i);
    rx_avail <= 2'h0;
  endtask
  task automatic s_slave();
    load(4'h8, 1'b0, 1'b0, 1'b0, 4'h0, 32'h800, 16'h0001);
    idle_for(5);
    @(posedge ref_clk_i);
    slave_req <= 2'h1;
    beat();
    chk(c, 4'h8);
    @(posedge ref_clk_i);
    slave_req <= 2'h0;
  endtask
  // rom-flagged master channel walks x then y; the rom select follows the channel
  task automatic s_two_d();
    logic [31:0] e;
    @(posedge ref_clk_i);
    tcb_we <= 1'b1;
    tcb_chan <= 4'h3;
    tcb <= '{active:1'b1, rom:1'b1, flyby:1'b0, hs:1'b0, to_ext:1'b0, chain:1'b0, chain_ch:4'h0,
             addr:32'h900, x_cnt:16'h0002, x_mod:16'h0004, x_left:16'h0002,
             y_left:16'h0002, y_mod:16'h0010};
    @(posedge ref_clk_i);
    tcb_we <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      beat();
      e = 32'h900 + (i[0] ? 32'h4 : 32'h0) + (i[1] ? 32'h14 : 32'h0);
      chk({c, a, rom_sel_n, to_ext}, {4'h3, e, 1'b0, 1'b0});
      chk(rom_addr, e[23:0]);
    end
    idle_for(2);
    chk(act[3], 1'b0);
  endtask
  task automatic s_flyby();
    int i;
    load(4'h1, 1'b0, 1'b1, 1'b0, 4'h0, 32'h0800_0000, 16'h0001);
    beat();
    chk({c, en_n}, {4'h1, 1'b1});
    @(posedge ref_clk_i);
    dly <= 2'h3;
    load(4'h0, 1'b0, 1'b1, 1'b0, 4'h0, 32'h0800_0000, 16'h0001);
    for (i = 0; i < 50 && en_n !== 1'b0; i++) @(negedge ref_clk_i);
    if (i == 50) begin
      n_mismatch++;
      tally_and_finish();
    end
    chk({rd_n, wr_n, bank_n, oe, rd_wr}, {1'b0, 1'b1, 4'hB, 1'b0, 1'b0});
    for (i = 0; i < 50 && ack !== 1'b1; i++) @(negedge ref_clk_i);
    if (i == 50) begin
      n_mismatch++;
      tally_and_finish();
    end
    chk({en_n, rd_n, oe}, {1'b0, 1'b0, 1'b0});
    repeat (3) @(negedge ref_clk_i);
    chk({en_n, rd_n, bank_n}, {1'b1, 1'b1, 4'hF});
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    reset_i = 1'b1;
    boot_en = 1'b1;
    boot_words = 16'h0002;
    tcb_we = 1'b0;
    tcb_chan = 4'h0;
    tcb = '0;
    dmar = 4'h0;
    tx_room = 2'h0;
    rx_avail = 2'h0;
    slave_req = 2'h0;
    rx_done_n = 2'h3;
    dly = 2'h2;
    repeat (12) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(negedge ref_clk_i);
    chk({rom_sel_n, xv, en_n, imem_we}, {1'b1, 1'b0, 1'b1, 1'b0});
    s_boot();
    @(posedge ref_clk_i);
    dly <= 2'h0;
    s_prio();
    s_link();
    s_rx_end_chain();
    s_slave();
    s_two_d();
    s_flyby();
    tally_and_finish();
  end
endmodule
